// *** rtl/swj_pin_pkg.sv ***
// Purpose: shared constants for the debug pin assignment block
// Assumes: 32-bit register bus, word aligned registers
// Notes: offsets are byte addresses
package swj_pin_pkg;
	// register map
	localparam logic [7:0] release_ctrl_off = 8'h00;
	localparam logic [7:0] pin_status_off = 8'h04;
	localparam logic [7:0] trace_ctrl_off = 8'h08;
	// release settings
	typedef enum logic [1:0] {
		release_full = 2'h0,
		release_no_treset = 2'h1,
		release_wire_only = 2'h2,
		release_all = 2'h3
	} release_mode_t;
	localparam logic [1:0] release_reset_value = 2'h0;
	localparam logic trace_reset_value = 1'b0;
	// pad levels while debug owned, pulls and core inputs after reset
	localparam logic [4:0] pad_idle_value = 5'h15;
	localparam logic [4:0] pull_up_reset_value = 5'h15;
	localparam logic [4:0] pull_down_reset_value = 5'h02;
	localparam logic [3:0] debug_in_reset_value = 4'hE;
	// pin indices
	localparam int pin_mode_select = 0;
	localparam int pin_test_clock = 1;
	localparam int pin_data_in = 2;
	localparam int pin_data_out = 3;
	localparam int pin_test_reset = 4;
	localparam int pin_count = 5;
	// bus response codes
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	// synchroniser depth
	localparam int sync_stages = 3;
endpackage : swj_pin_pkg

// *** rtl/pin_sync.sv ***
// Purpose: three-stage synchroniser for one pin input
// Assumes: input is asynchronous to clk_i
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter logic idle_level = 1'b0
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic async_i,
	output logic sync_o
);
	logic [swj_pin_pkg::sync_stages-1:0] stage_ff;
	logic [swj_pin_pkg::sync_stages-1:0] nxt_stage;
	logic held_ff;
	logic nxt_held;

	// shift chain; first stage read only by the second
	always_comb begin
		nxt_stage = {stage_ff[swj_pin_pkg::sync_stages-2:0], async_i};
		nxt_held = held_ff;
		if (stage_ff[1] == stage_ff[2]) begin
			nxt_held = stage_ff[2];
		end
	end

	always_ff @(posedge clk_i) begin
		// start at the pin's idle level so no false edge follows reset
		if (reset_i) begin
			stage_ff <= {swj_pin_pkg::sync_stages{idle_level}};
			held_ff <= idle_level;
		end else begin
			stage_ff <= nxt_stage;
			held_ff <= nxt_held;
		end
	end

	assign sync_o = held_ff;
endmodule : pin_sync
`default_nettype wire

// *** rtl/swj_pin_assign.sv ***
// Purpose: ownership and pull control of the five shared debug pins
// Assumes: register access over AXI4-Lite, pins sampled on clk_i
// Notes: the debug port core itself lies outside this block
`timescale 1ns/1ps
`default_nettype none
module swj_pin_assign (
	input wire logic clk_i,
	input wire logic reset_i,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pad side: input, output, output enable per pin
	input wire logic [4:0] pad_in_i,
	output logic [4:0] pad_out_o,
	output logic [4:0] pad_oe_o,
	output logic [4:0] pad_pull_up_o,
	output logic [4:0] pad_pull_down_o,
	// GPIO controller side
	input wire logic [4:0] gpio_out_i,
	input wire logic [4:0] gpio_oe_i,
	input wire logic [4:0] gpio_pull_up_i,
	input wire logic [4:0] gpio_pull_down_i,
	output logic [4:0] gpio_in_o,
	output logic [4:0] gpio_owned_o,
	// debug port core side
	input wire logic wire_mode_i,
	input wire logic wire_data_out_i,
	input wire logic wire_data_oe_i,
	input wire logic test_data_out_i,
	input wire logic trace_wire_output_i,
	input wire logic probe_trace_enable_i,
	output logic test_clock_or_wire_clock_o,
	output logic mode_select_or_wire_data_o,
	output logic test_data_in_o,
	output logic test_reset_low_o
);
	// pin owner mask from a release setting, used for next state and status
	function automatic logic [4:0] debug_owned(input logic [1:0] mode);
		logic [4:0] m;
		m = 5'h1F;
		unique case (swj_pin_pkg::release_mode_t'(mode))
			swj_pin_pkg::release_full: m = 5'h1F;
			swj_pin_pkg::release_no_treset: m = 5'h0F;
			swj_pin_pkg::release_wire_only: m = 5'h03;
			swj_pin_pkg::release_all: m = 5'h00;
		endcase
		return m;
	endfunction : debug_owned

	// bus and configuration state
	logic [1:0] release_ff, nxt_release;
	logic trace_ff, nxt_trace;
	logic awhave_ff, nxt_awhave;
	logic [7:0] awaddr_ff, nxt_awaddr;
	logic whave_ff, nxt_whave;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	logic arready_ff, nxt_arready;
	logic awready_ff, nxt_awready;
	logic wready_ff, nxt_wready;

	// pin state
	logic [4:0] pad_sync;
	logic [4:0] owned;
	logic [4:0] pad_out_ff, nxt_pad_out;
	logic [4:0] pad_oe_ff, nxt_pad_oe;
	logic [4:0] pu_ff, nxt_pu;
	logic [4:0] pd_ff, nxt_pd;
	logic [4:0] gpio_in_ff, nxt_gpio_in;
	logic [4:0] gpio_owned_ff, nxt_gpio_owned;
	logic [3:0] dbg_in_ff, nxt_dbg_in;

	// every pad input is from outside the clock domain
	genvar g;
	generate
		for (g = 0; g < swj_pin_pkg::pin_count; g++) begin : g_sync
			pin_sync #(
				.idle_level(swj_pin_pkg::pad_idle_value[g])
			) u_sync (
				.clk_i(clk_i),
				.reset_i(reset_i),
				.async_i(pad_in_i[g]),
				.sync_o(pad_sync[g])
			);
		end
	endgenerate

	assign owned = debug_owned(release_ff);

	// write path: address and data taken in either order, response after both
	always_comb begin
		nxt_awhave = awhave_ff;
		nxt_awaddr = awaddr_ff;
		nxt_whave = whave_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_release = release_ff;
		nxt_trace = trace_ff;
		// taken only with ready high; ready is still low the cycle after reset
		if (s_axi_awvalid && awready_ff) begin
			nxt_awhave = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_ff) begin
			nxt_whave = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (awhave_ff && whave_ff) begin
			nxt_awhave = 1'b0;
			nxt_whave = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = swj_pin_pkg::resp_okay;
			unique case (awaddr_ff[7:2])
				swj_pin_pkg::release_ctrl_off[7:2]: begin
					if (wstrb_ff[0]) begin
						nxt_release = wdata_ff[1:0];
					end
				end
				swj_pin_pkg::trace_ctrl_off[7:2]: begin
					if (wstrb_ff[0]) begin
						nxt_trace = wdata_ff[0];
					end
				end
				swj_pin_pkg::pin_status_off[7:2]: begin
					nxt_bresp = swj_pin_pkg::resp_okay; // read-only, write ignored
				end
				default: begin
					nxt_bresp = swj_pin_pkg::resp_slverr;
				end
			endcase
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
	end

	// read path: one read at a time, answer one cycle after address
	always_comb begin
		nxt_arready = 1'b0;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_arvalid && !arready_ff && !rvalid_ff) begin
			nxt_arready = 1'b1;
			nxt_rvalid = 1'b1;
			nxt_rresp = swj_pin_pkg::resp_okay;
			unique case (s_axi_araddr[7:2])
				swj_pin_pkg::release_ctrl_off[7:2]: nxt_rdata = {30'h0, release_ff};
				swj_pin_pkg::trace_ctrl_off[7:2]: nxt_rdata = {31'h0, trace_ff};
				swj_pin_pkg::pin_status_off[7:2]: begin
					nxt_rdata = {19'h0, pad_sync, 3'h0, owned};
				end
				default: begin
					nxt_rdata = 32'h0;
					nxt_rresp = swj_pin_pkg::resp_slverr;
				end
			endcase
		end
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	// pad ownership, direction and pulls
	always_comb begin
		nxt_pad_out = gpio_out_i;
		nxt_pad_oe = gpio_oe_i;
		nxt_pu = gpio_pull_up_i;
		nxt_pd = gpio_pull_down_i;
		nxt_gpio_owned = ~owned;
		nxt_gpio_in = pad_sync & ~owned;
		nxt_dbg_in = {pad_sync[swj_pin_pkg::pin_test_reset], pad_sync[swj_pin_pkg::pin_data_in],
			pad_sync[swj_pin_pkg::pin_mode_select], pad_sync[swj_pin_pkg::pin_test_clock]};
		// mode select: input in JTAG, two-way wire data in serial wire mode
		if (owned[swj_pin_pkg::pin_mode_select]) begin
			nxt_pad_out[swj_pin_pkg::pin_mode_select] = wire_data_out_i;
			nxt_pad_oe[swj_pin_pkg::pin_mode_select] = wire_mode_i & wire_data_oe_i;
			nxt_pu[swj_pin_pkg::pin_mode_select] = 1'b1;
			nxt_pd[swj_pin_pkg::pin_mode_select] = 1'b0;
		end
		// clock is an input in both modes
		if (owned[swj_pin_pkg::pin_test_clock]) begin
			nxt_pad_out[swj_pin_pkg::pin_test_clock] = 1'b0;
			nxt_pad_oe[swj_pin_pkg::pin_test_clock] = 1'b0;
			nxt_pu[swj_pin_pkg::pin_test_clock] = 1'b0;
			nxt_pd[swj_pin_pkg::pin_test_clock] = 1'b1;
		end
		if (owned[swj_pin_pkg::pin_data_in]) begin
			nxt_pad_out[swj_pin_pkg::pin_data_in] = 1'b0;
			nxt_pad_oe[swj_pin_pkg::pin_data_in] = 1'b0;
			nxt_pu[swj_pin_pkg::pin_data_in] = 1'b1;
			nxt_pd[swj_pin_pkg::pin_data_in] = 1'b0;
		end
		// data out carries trace only when the probe asked and software allows
		if (owned[swj_pin_pkg::pin_data_out]) begin
			nxt_pad_out[swj_pin_pkg::pin_data_out] = test_data_out_i;
			nxt_pad_oe[swj_pin_pkg::pin_data_out] = ~wire_mode_i;
			if (wire_mode_i && probe_trace_enable_i && trace_ff) begin
				nxt_pad_out[swj_pin_pkg::pin_data_out] = trace_wire_output_i;
				nxt_pad_oe[swj_pin_pkg::pin_data_out] = 1'b1;
			end
			nxt_pu[swj_pin_pkg::pin_data_out] = 1'b0;
			nxt_pd[swj_pin_pkg::pin_data_out] = 1'b0;
		end
		if (owned[swj_pin_pkg::pin_test_reset]) begin
			nxt_pad_out[swj_pin_pkg::pin_test_reset] = 1'b0;
			nxt_pad_oe[swj_pin_pkg::pin_test_reset] = 1'b0;
			nxt_pu[swj_pin_pkg::pin_test_reset] = 1'b1;
			nxt_pd[swj_pin_pkg::pin_test_reset] = 1'b0;
		end
		// released debug inputs read idle so the port core sees no stray edges
		if (!owned[swj_pin_pkg::pin_test_clock]) begin
			nxt_dbg_in[0] = 1'b0;
		end
		if (!owned[swj_pin_pkg::pin_mode_select]) begin
			nxt_dbg_in[1] = 1'b1;
		end
		if (!owned[swj_pin_pkg::pin_data_in]) begin
			nxt_dbg_in[2] = 1'b1;
		end
		if (!owned[swj_pin_pkg::pin_test_reset]) begin
			nxt_dbg_in[3] = 1'b1; // held inactive, not in reset
		end
	end

	// registers; reset gives full debug ownership with debug pulls
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			release_ff <= swj_pin_pkg::release_reset_value;
			trace_ff <= swj_pin_pkg::trace_reset_value;
			awhave_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			whave_ff <= 1'b0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= 2'h0;
			arready_ff <= 1'b0;
			pad_out_ff <= 5'h00;
			pad_oe_ff <= 5'h00;
			pu_ff <= swj_pin_pkg::pull_up_reset_value;
			pd_ff <= swj_pin_pkg::pull_down_reset_value;
			gpio_in_ff <= 5'h00;
			gpio_owned_ff <= 5'h00;
			dbg_in_ff <= swj_pin_pkg::debug_in_reset_value;
		end else begin
			release_ff <= nxt_release;
			trace_ff <= nxt_trace;
			awhave_ff <= nxt_awhave;
			awaddr_ff <= nxt_awaddr;
			whave_ff <= nxt_whave;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			arready_ff <= nxt_arready;
			pad_out_ff <= nxt_pad_out;
			pad_oe_ff <= nxt_pad_oe;
			pu_ff <= nxt_pu;
			pd_ff <= nxt_pd;
			gpio_in_ff <= nxt_gpio_in;
			gpio_owned_ff <= nxt_gpio_owned;
			dbg_in_ff <= nxt_dbg_in;
		end
	end

	// ready only while a slot is free; registered for flop-driven outputs
	always_comb begin
		nxt_awready = !nxt_awhave && !nxt_bvalid;
		nxt_wready = !nxt_whave && !nxt_bvalid;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
		end else begin
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign pad_out_o = pad_out_ff;
	assign pad_oe_o = pad_oe_ff;
	assign pad_pull_up_o = pu_ff;
	assign pad_pull_down_o = pd_ff;
	assign gpio_in_o = gpio_in_ff;
	assign gpio_owned_o = gpio_owned_ff;
	assign test_clock_or_wire_clock_o = dbg_in_ff[0];
	assign mode_select_or_wire_data_o = dbg_in_ff[1];
	assign test_data_in_o = dbg_in_ff[2];
	assign test_reset_low_o = dbg_in_ff[3];
endmodule : swj_pin_assign
`default_nettype wire

// *** tb/swj_pin_chk.sv ***
// Purpose: port checks for the debug pin assignment block
// Assumes: one clock domain, synchronous reset
// Notes: pads and pulls move together with gpio_owned_o
`timescale 1ns/1ps
`default_nettype none
module swj_pin_chk (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] gpio_owned_o,
	input wire logic [4:0] gpio_pull_up_i,
	input wire logic [4:0] pad_pull_up_o,
	input wire logic [4:0] pad_pull_down_o,
	input wire logic [4:0] pad_oe_o,
	input wire logic wire_mode_i,
	input wire logic probe_trace_enable_i,
	input wire logic test_clock_or_wire_clock_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// address and data taken at one edge
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	AST_WR_ANSWER: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("write response missing");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	AST_RESET_STATE: assert property ($fell(reset_i) |-> gpio_owned_o == 5'h00
		&& pad_pull_up_o == 5'h15 && pad_pull_down_o == 5'h02) else $error("bad reset state");
	AST_OWNED_PULLS: assert property ((((pad_pull_up_o ^ 5'h15) | (pad_pull_down_o ^ 5'h02))
		& ~gpio_owned_o) == 5'h00) else $error("debug pin pulls wrong");
	AST_REL_PULLS: assert property ((($past(gpio_pull_up_i) ^ pad_pull_up_o)
		& gpio_owned_o) == 5'h00) else $error("released pin pull wrong");
	AST_MASK_LEGAL: assert property (gpio_owned_o inside {5'h00, 5'h10, 5'h1C, 5'h1F})
		else $error("illegal release mask");
	AST_SELECT_IN: assert property (!gpio_owned_o[0] && !$past(wire_mode_i)
		|-> !pad_oe_o[0]) else $error("select pin driven in jtag mode");
	AST_CLOCK_IN: assert property (!gpio_owned_o[1] |-> !pad_oe_o[1])
		else $error("clock pin driven");
	AST_NO_TRACE: assert property ($past(wire_mode_i) && !$past(probe_trace_enable_i)
		&& !gpio_owned_o[3] |-> !pad_oe_o[3]) else $error("trace without probe");
	AST_CLOCK_IDLE: assert property ($past(gpio_owned_o[1], 2) && $past(gpio_owned_o[1])
		|-> !test_clock_or_wire_clock_o) else $error("released clock reaches core");
endmodule : swj_pin_chk
bind swj_pin_assign swj_pin_chk swj_pin_chk_i (.*);
`default_nettype wire

// *** tb/probe_model.sv ***
// Purpose: behavioural debug probe on the shared pins
// Assumes: bench raises frame_i around probe traffic
// Notes: lvl ordering is test reset low, data in, mode select
`timescale 1ns/1ps
`default_nettype none
module probe_model (
	input wire logic frame_i,
	input wire logic [2:0] lvl_i,
	output logic tck_o,
	output logic [2:0] lvl_o
);
	// 800 ns link clock, resting low between frames so no stray edges
	initial begin
		tck_o = 1'b0;
		forever begin
			#400;
			tck_o = frame_i ? ~tck_o : 1'b0;
		end
	end
	// released lines settle at their pull-up level, never float
	assign lvl_o = frame_i ? lvl_i : 3'h7;
endmodule : probe_model
`default_nettype wire

// *** tb/test_swj_pin_assign.sv ***
// Purpose: self-checking bench for the debug pin assignment block
// Assumes: AXI4-Lite master in bench, probe model on pads
// Notes: pin inputs pass a synchroniser, so checks wait a few cycles
`timescale 1ns/1ps
`default_nettype none
module test_swj_pin_assign;
	logic clk_i, reset_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [4:0] pad_in_i, pad_out_o, pad_oe_o, pad_pull_up_o, pad_pull_down_o, gpio_in_o;
	logic [4:0] gpio_out_i, gpio_oe_i, gpio_pull_up_i, gpio_pull_down_i, gpio_owned_o;
	logic wire_mode_i, wire_data_out_i, wire_data_oe_i, test_data_out_i, trace_wire_output_i;
	logic probe_trace_enable_i, test_clock_or_wire_clock_o, mode_select_or_wire_data_o;
	logic test_data_in_o, test_reset_low_o, frame, tck;
	logic [2:0] lvl, plvl;
	int errors, tests_run;
	swj_pin_assign swj_pin_assign_i (.*);
	probe_model probe_model_i (.frame_i(frame), .lvl_i(lvl), .tck_o(tck), .lvl_o(plvl));
	// undriven data out pad shows the inverse of its output level, not a lucky value
	assign pad_in_i = {plvl[2], pad_oe_o[3] ? pad_out_o[3] : ~pad_out_o[3], plvl[1], tck,
		pad_oe_o[0] ? pad_out_o[0] : plvl[0]};
	// 10 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge clk_i);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic t_reset();
		chk(gpio_owned_o, 5'h00);
		chk(pad_pull_up_o, 5'h15);
		chk(pad_pull_down_o, 5'h02);
		// core inputs must sit idle right after reset, no false edge
		chk({test_reset_low_o, test_data_in_o, mode_select_or_wire_data_o,
			test_clock_or_wire_clock_o}, 4'hE);
		rd(swj_pin_pkg::release_ctrl_off, d, r);
		chk(d, 32'h0);
		rd(swj_pin_pkg::trace_ctrl_off, d, r);
		chk(d, 32'h0);
		$display("reset test done");
	endtask : t_reset
	// strobe, read-only status and unmapped places
	task automatic t_bus();
		wr(8'h00, 32'h1, r);
		s_axi_wstrb <= 4'h0;
		wr(8'h00, 32'h3, r);
		s_axi_wstrb <= 4'hF;
		wr(8'h04, 32'h3, r);
		chk(r, swj_pin_pkg::resp_okay);
		rd(8'h00, d, r);
		chk(d, 32'h1);
		rd(8'h0C, d, r);
		chk(r, swj_pin_pkg::resp_slverr);
		chk(d, 32'h0);
		wr(8'h0C, 32'h1, r);
		chk(r, swj_pin_pkg::resp_slverr);
		$display("bus test done");
	endtask : t_bus
	task automatic t_modes();
		logic [4:0] dbg [4] = '{5'h1F, 5'h0F, 5'h03, 5'h00};
		logic [4:0] m, n;
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, 32'(i), r);
			rd(8'h00, d, r);
			chk(d, 32'(i));
			cyc(2);
			m = dbg[i];
			n = ~m;
			chk(gpio_owned_o, n);
			chk(pad_pull_up_o, (5'h15 & m) | (gpio_pull_up_i & n));
			chk(pad_pull_down_o, (5'h02 & m) | (gpio_pull_down_i & n));
			chk(pad_oe_o & n, 5'h00);
		end
		wr(8'h00, 32'h0, r);
		$display("mode test done");
	endtask : t_modes
	task automatic t_sync();
		int n;
		logic c;
		n = 0;
		lvl <= 3'h2;
		frame <= 1'b1;
		cyc(6);
		chk(test_data_in_o, 1'b1);
		chk(mode_select_or_wire_data_o, 1'b0);
		chk(test_reset_low_o, 1'b0);
		c = test_clock_or_wire_clock_o;
		repeat (24) begin
			@(posedge clk_i);
			if (test_clock_or_wire_clock_o !== c) n++;
			c = test_clock_or_wire_clock_o;
		end
		chk(n >= 3, 1'b1);
		frame <= 1'b0;
		cyc(10);
		chk(test_clock_or_wire_clock_o, 1'b0);
		$display("sync test done");
	endtask : t_sync
	// bits: wire mode, probe trace, software trace, data out driven
	task automatic t_trace();
		logic [3:0] tv [4] = '{4'h1, 4'hC, 4'hF, 4'hA};
		test_data_out_i <= 1'b1;
		foreach (tv[i]) begin
			wr(8'h08, {31'h0, tv[i][1]}, r);
			wire_mode_i <= tv[i][3];
			probe_trace_enable_i <= tv[i][2];
			cyc(2);
			chk(pad_oe_o[3], tv[i][0]);
			if (tv[i][0]) chk(pad_out_o[3], !tv[i][3]);
		end
		wire_data_oe_i <= 1'b1;
		wire_data_out_i <= 1'b1;
		cyc(2);
		chk(pad_oe_o[0], 1'b1);
		chk(pad_out_o[0], 1'b1);
		wire_data_oe_i <= 1'b0;
		wire_mode_i <= 1'b0;
		$display("trace test done");
	endtask : t_trace
	task automatic t_gpio();
		gpio_oe_i <= 5'h1F;
		gpio_out_i <= 5'h0A;
		gpio_pull_up_i <= 5'h0A;
		wr(8'h00, 32'h3, r);
		lvl <= 3'h0;
		frame <= 1'b1;
		cyc(8);
		chk(pad_oe_o, 5'h1F);
		chk(pad_out_o, 5'h0A);
		chk(pad_pull_up_o, 5'h0A);
		chk(gpio_in_o & 5'h1D, 5'h08);
		chk(test_reset_low_o, 1'b1);
		frame <= 1'b0;
		gpio_oe_i <= 5'h00;
		cyc(10);
		chk(gpio_in_o, 5'h15);
		$display("gpio test done");
	endtask : t_gpio
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	// main sequence, GPIO side starts in its own reset state
	initial begin
		{reset_i, s_axi_wstrb, gpio_pull_up_i, gpio_pull_down_i} = {1'b1, 4'hF, 5'h15, 5'h02};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, gpio_out_i, gpio_oe_i} = 58'h0;
		{wire_mode_i, wire_data_out_i, wire_data_oe_i, test_data_out_i} = 4'h0;
		{trace_wire_output_i, probe_trace_enable_i, frame, lvl} = 6'h07;
		errors = 0;
		tests_run = 0;
		cyc(5);
		reset_i <= 1'b0;
		cyc(2);
		t_reset();
		t_bus();
		t_modes();
		t_sync();
		t_trace();
		t_gpio();
		end_of_test();
	end
	// whole run is under two hundred cycles; this only cuts a hang
	initial begin
		cyc(5000);
		errors++;
		end_of_test();
	end
endmodule : test_swj_pin_assign
`default_nettype wire
